//--- crr_map.svh
// register indices, field positions, reset values and counts of the channel config block
`ifndef CRR_MAP_SVH
`define CRR_MAP_SVH
`define CRR_CTRL_IDX0      6'h06
`define CRR_CTRL_IDX1      6'h0E
`define CRR_CTRL_IDX2      6'h16
`define CRR_JA_IDX0        6'h07
`define CRR_JA_IDX1        6'h0F
`define CRR_JA_IDX2        6'h17
`define CRR_IRQ_STAT_IDX   6'h20
`define CRR_IRQ_MASK_IDX   6'h21
`define CRR_CTRL_RAIL_BIT  0
`define CRR_CTRL_RATE_BIT  1
`define CRR_CTRL_THIRD_BIT 2
`define CRR_CTRL_W         3
`define CRR_CTRL_RST       3'h0
`define CRR_JA_LOW_BIT     0
`define CRR_JA_TXPATH_BIT  1
`define CRR_JA_HIGH_BIT    2
`define CRR_JA_RESET_BIT   3
`define CRR_JA_RECOV_BIT   4
`define CRR_JA_W           5
`define CRR_JA_RST         5'h00
`define CRR_IRQ_RST        3'h0
`define CRR_EXZ_SLOW       3'h3
`define CRR_EXZ_E3         3'h4
`define CRR_SYNC_W         6
`endif

//--- crr_pkg.sv
// types shared by the channel rate, rail and attenuator config block
package crr_pkg;
  typedef enum logic [1:0] {
    CRR_RATE_DS3,
    CRR_RATE_STS1,
    CRR_RATE_E3
  } crr_rate_t;
  typedef enum logic [1:0] {
    CRR_REG_NONE,
    CRR_REG_CTRL,
    CRR_REG_JA,
    CRR_REG_IRQ
  } crr_reg_kind_t;
endpackage

//--- crr_channel_config.sv
// three-channel rate, rail-format and jitter-attenuator config with AHB-Lite registers
// Operation
// - third-rate bit clear: rate-select 0 gives DS3, 1 gives STS-1.
// - third-rate bit set: rate-select ignored, channel runs E3.
// - rail select 0 is dual-rail, 1 single-rail; resets to dual-rail.
// - single-rail: codec enabled, transmit data taken from one input.
// - single-rail: all receive data on positive output, negative flags violations.
// - dual-rail: codec disabled, transmit takes positive and negative inputs separately.
// - dual-rail: each received pulse drives matching output for one recovered period.
// - one 8-bit attenuator register per channel at 0x07/0x0F/0x17; bits 7-5 zero.
// - recovery-time bit 0 enables 50ms recovery mode; 1 disables it.
// - third-rate bit 1 gives E3, else DS3 or STS-1 by rate-select.
// - 0-to-1 write of attenuator reset bit clears FIFO pointers; software rewrites 0.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "crr_map.svh"
module crr_channel_config
  import crr_pkg::*;
#(
  parameter int NCH = 3
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [NCH-1:0]    rx_clk_in,
  input  wire logic [NCH-1:0]    line_rx_plus,
  input  wire logic [NCH-1:0]    line_rx_minus,
  input  wire logic [NCH-1:0]    tx_clk_in,
  input  wire logic [NCH-1:0]    tx_positive_data_in,
  input  wire logic [NCH-1:0]    tx_negative_data_in,
  output logic      [NCH-1:0]    rx_positive_out,
  output logic      [NCH-1:0]    rx_negative_or_violation_out,
  output logic      [NCH-1:0]    tx_line_pos_out,
  output logic      [NCH-1:0]    tx_line_neg_out,
  output logic      [NCH-1:0]    codec_enable,
  output logic      [2*NCH-1:0]  chan_rate,
  output logic      [2*NCH-1:0]  atten_cfg,
  output logic      [NCH-1:0]    atten_tx_path_select,
  output logic      [NCH-1:0]    atten_fifo_reset,
  output logic      [NCH-1:0]    aps_recovery_enable,
  output logic                   irq
);

  function automatic crr_reg_kind_t reg_kind(input logic [5:0] idx);
    if (idx == `CRR_CTRL_IDX0 || idx == `CRR_CTRL_IDX1 || idx == `CRR_CTRL_IDX2) begin
      return CRR_REG_CTRL;
    end else if (idx == `CRR_JA_IDX0 || idx == `CRR_JA_IDX1 || idx == `CRR_JA_IDX2) begin
      return CRR_REG_JA;
    end else if (idx == `CRR_IRQ_STAT_IDX || idx == `CRR_IRQ_MASK_IDX) begin
      return CRR_REG_IRQ;
    end else begin
      return CRR_REG_NONE;
    end
  endfunction

  function automatic logic [1:0] reg_chan(input logic [5:0] idx);
    if (idx == `CRR_CTRL_IDX1 || idx == `CRR_JA_IDX1) begin
      return 2'h1;
    end else if (idx == `CRR_CTRL_IDX2 || idx == `CRR_JA_IDX2) begin
      return 2'h2;
    end else begin
      return 2'h0;
    end
  endfunction

  logic                 ap_take;
  logic [5:0]           ap_idx;
  logic                 wr_pend_r;
  logic [5:0]           wr_idx_r;
  crr_reg_kind_t        wr_kind;
  logic [1:0]           wr_chan;
  logic [31:0]          hrdata_r;
  logic [2:0]           stat_r;
  logic [2:0]           mask_r;
  logic [NCH-1:0]       vio_evt;
  logic [3*NCH-1:0]     ctrl_all;
  logic [5*NCH-1:0]     ja_all;
  logic                 rd_stat;

  // hsize is not checked: only whole-word transfers are issued
  assign ap_take   = hsel & htrans[1] & hready;
  assign ap_idx    = haddr[7:2];
  assign wr_kind   = reg_kind(wr_idx_r);
  assign wr_chan   = reg_chan(wr_idx_r);
  assign rd_stat   = ap_take & ~hwrite & (ap_idx == `CRR_IRQ_STAT_IDX);
  // zero wait state: every access completes in its first data-phase cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign irq       = |(stat_r & mask_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 6'h00;
    end else begin
      wr_pend_r <= ap_take & hwrite;
      if (ap_take) begin
        wr_idx_r <= ap_idx;
      end
    end
  end

  // read data is latched at the address phase so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      hrdata_r <= 32'h0000_0000;
      if (reg_kind(ap_idx) == CRR_REG_CTRL) begin
        hrdata_r[`CRR_CTRL_W-1:0] <= ctrl_all[3*reg_chan(ap_idx) +: 3];
      end else if (reg_kind(ap_idx) == CRR_REG_JA) begin
        hrdata_r[`CRR_JA_W-1:0] <= ja_all[5*reg_chan(ap_idx) +: 5];
      end else if (ap_idx == `CRR_IRQ_STAT_IDX) begin
        hrdata_r[2:0] <= stat_r;
      end else if (ap_idx == `CRR_IRQ_MASK_IDX) begin
        hrdata_r[2:0] <= mask_r;
      end
    end
  end

  // a violation in the same cycle as the clearing read survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= `CRR_IRQ_RST;
    end else begin
      stat_r <= (stat_r & ~{3{rd_stat}}) | vio_evt[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= `CRR_IRQ_RST;
    end else if (wr_pend_r && wr_idx_r == `CRR_IRQ_MASK_IDX) begin
      mask_r <= hwdata[2:0];
    end
  end

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic [`CRR_SYNC_W-1:0] s1_r;
      logic [`CRR_SYNC_W-1:0] s2_r;
      logic                   rclk_d_r;
      logic                   tclk_d_r;
      logic                   rx_edge;
      logic                   tx_edge;
      logic [2:0]             ctrl_r;
      logic [4:0]             ja_r;
      logic                   rst_pulse_r;
      logic                   rxp_r;
      logic                   rxn_r;
      logic                   txp_r;
      logic                   txn_r;
      logic                   last_pos_r;
      logic                   seen_pulse_r;
      logic [2:0]             zrun_r;
      logic                   tx_pol_r;
      logic                   evt_r;
      logic                   single;
      logic                   pulse_p;
      logic                   pulse_m;
      logic                   bpv;
      logic                   exz;
      logic [2:0]             exz_lim;
      logic                   wr_here;
      crr_rate_t              rate;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_r <= '0;
          s2_r <= '0;
        end else begin
          s1_r <= {tx_negative_data_in[i], tx_positive_data_in[i], tx_clk_in[i],
                   line_rx_minus[i], line_rx_plus[i], rx_clk_in[i]};
          s2_r <= s1_r;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rclk_d_r <= 1'b0;
          tclk_d_r <= 1'b0;
        end else begin
          rclk_d_r <= s2_r[0];
          tclk_d_r <= s2_r[3];
        end
      end

      assign rx_edge = s2_r[0] & ~rclk_d_r;
      assign tx_edge = s2_r[3] & ~tclk_d_r;
      assign pulse_p = s2_r[1];
      assign pulse_m = s2_r[2];
      assign wr_here = wr_pend_r && wr_chan == 2'(i);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ctrl_r <= `CRR_CTRL_RST;
        end else if (wr_here && wr_kind == CRR_REG_CTRL) begin
          ctrl_r <= hwdata[`CRR_CTRL_W-1:0];
        end
      end

      // pointer reset fires once per rising write; the bit stays set until software clears it
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ja_r        <= `CRR_JA_RST;
          rst_pulse_r <= 1'b0;
        end else begin
          rst_pulse_r <= 1'b0;
          if (wr_here && wr_kind == CRR_REG_JA) begin
            ja_r        <= hwdata[`CRR_JA_W-1:0];
            rst_pulse_r <= hwdata[`CRR_JA_RESET_BIT] & ~ja_r[`CRR_JA_RESET_BIT];
          end
        end
      end

      assign single = ctrl_r[`CRR_CTRL_RAIL_BIT];
      always_comb begin
        if (ctrl_r[`CRR_CTRL_THIRD_BIT]) begin
          rate = CRR_RATE_E3;
        end else if (ctrl_r[`CRR_CTRL_RATE_BIT]) begin
          rate = CRR_RATE_STS1;
        end else begin
          rate = CRR_RATE_DS3;
        end
      end
      assign exz_lim = (rate == CRR_RATE_E3) ? `CRR_EXZ_E3 : `CRR_EXZ_SLOW;

      // decoder only flags line faults; substitution patterns are passed as marks
      assign bpv = seen_pulse_r & ((pulse_p & last_pos_r) | (pulse_m & ~last_pos_r));
      // compare against limit-1 because the run counter does not yet include the current zero
      assign exz = ~(pulse_p | pulse_m) & (zrun_r >= exz_lim - 3'h1);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rxp_r        <= 1'b0;
          rxn_r        <= 1'b0;
          last_pos_r   <= 1'b0;
          seen_pulse_r <= 1'b0;
          zrun_r       <= 3'h0;
          evt_r        <= 1'b0;
        end else begin
          evt_r <= 1'b0;
          if (rx_edge) begin
            if (single) begin
              rxp_r <= pulse_p | pulse_m;
              rxn_r <= bpv | exz;
              evt_r <= bpv | exz;
            end else begin
              rxp_r <= pulse_p;
              rxn_r <= pulse_m;
            end
            if (pulse_p | pulse_m) begin
              last_pos_r   <= pulse_p;
              seen_pulse_r <= 1'b1;
              zrun_r       <= 3'h0;
            end else if (zrun_r != 3'h7) begin
              zrun_r <= zrun_r + 3'h1;
            end
          end
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          txp_r    <= 1'b0;
          txn_r    <= 1'b0;
          tx_pol_r <= 1'b0;
        end else if (tx_edge) begin
          if (single) begin
            // alternate mark polarity from the one data input
            txp_r <= s2_r[4] & ~tx_pol_r;
            txn_r <= s2_r[4] & tx_pol_r;
            if (s2_r[4]) begin
              tx_pol_r <= ~tx_pol_r;
            end
          end else begin
            txp_r <= s2_r[4];
            txn_r <= s2_r[5];
          end
        end
      end

      assign ctrl_all[3*i +: 3]              = ctrl_r;
      assign ja_all[5*i +: 5]                = ja_r;
      assign vio_evt[i]                      = evt_r;
      assign rx_positive_out[i]              = rxp_r;
      assign rx_negative_or_violation_out[i] = rxn_r;
      assign tx_line_pos_out[i]              = txp_r;
      assign tx_line_neg_out[i]              = txn_r;
      assign codec_enable[i]                 = single;
      assign chan_rate[2*i +: 2]             = rate;
      assign atten_cfg[2*i +: 2]             = {ja_r[`CRR_JA_HIGH_BIT], ja_r[`CRR_JA_LOW_BIT]};
      assign atten_tx_path_select[i]         = ja_r[`CRR_JA_TXPATH_BIT];
      assign atten_fifo_reset[i]             = rst_pulse_r;
      assign aps_recovery_enable[i]          = ~ja_r[`CRR_JA_RECOV_BIT];
    end
  endgenerate

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  rate_e3_sel_a: assert property (ctrl_all[2] |-> chan_rate[1:0] == CRR_RATE_E3)
    else $error("third-rate bit set but channel not in E3");
  rate_slow_sel_a: assert property (!ctrl_all[2] |-> chan_rate[1:0] == {1'b0, ctrl_all[1]})
    else $error("rate select not honoured");
  rate_e3_write_a: assert property (wr_pend_r && wr_idx_r == `CRR_CTRL_IDX0 && hwdata[2]
                                    |=> chan_rate[1:0] == CRR_RATE_E3)
    else $error("E3 write did not take effect");
  rail_codec_a: assert property (wr_pend_r && wr_idx_r == `CRR_CTRL_IDX0
                                 |=> codec_enable[0] == $past(hwdata[0]))
    else $error("codec enable does not follow rail select");
  single_rx_a: assert property (g_ch[0].rx_edge && codec_enable[0]
                                |=> rx_positive_out[0] == $past(line_rx_plus[0] | line_rx_minus[0], 3))
    else $error("single-rail receive data wrong");
  dual_rx_hold_a: assert property (!codec_enable[0] && !g_ch[0].rx_edge |=> $stable(rx_positive_out[0])
                                   && $stable(rx_negative_or_violation_out[0]))
    else $error("dual-rail output changed between recovered edges");
  dual_tx_a: assert property (g_ch[0].tx_edge && !codec_enable[0]
                              |=> tx_line_neg_out[0] == $past(tx_negative_data_in[0], 3))
    else $error("dual-rail transmit negative data lost");
  ja_upper_zero_a: assert property (ap_take && !hwrite && reg_kind(ap_idx) == CRR_REG_JA
                                    |=> hrdata[7:5] == 3'h0)
    else $error("attenuator unused bits not zero");
  ja_reset_edge_a: assert property (wr_pend_r && wr_idx_r == `CRR_JA_IDX0 && hwdata[3] && !ja_all[3]
                                    |=> atten_fifo_reset[0] ##1 !atten_fifo_reset[0])
    else $error("attenuator reset pulse wrong");
  recovery_mode_a: assert property (aps_recovery_enable[0] == !ja_all[4])
    else $error("recovery mode does not follow its bit");
  tx_path_a: assert property (atten_tx_path_select[0] == ja_all[1])
    else $error("attenuator path select wrong");
  irq_level_a: assert property (vio_evt[0] && mask_r[0] |=> irq)
    else $error("interrupt not raised after unmasked violation");

  e3_mode_c: cover property (chan_rate[1:0] == CRR_RATE_E3);
  violation_c: cover property (vio_evt[0] ##[1:20] irq);
  ja_reset_c: cover property (atten_fifo_reset[0]);
  dual_pulse_c: cover property (!codec_enable[0] && rx_negative_or_violation_out[0]);

endmodule

//--- crr_link_partner.sv
// line-side and system-side traffic model for the channel config block
`timescale 1ns/10ps
module crr_link_partner #(
  parameter int NCH = 3
) (
  output logic [NCH-1:0] rx_clk_in,
  output logic [NCH-1:0] line_rx_plus,
  output logic [NCH-1:0] line_rx_minus,
  output logic [NCH-1:0] tx_clk_in,
  output logic [NCH-1:0] tx_positive_data_in,
  output logic [NCH-1:0] tx_negative_data_in
);
  initial begin
    rx_clk_in = '0;
    line_rx_plus = '0;
    line_rx_minus = '0;
    tx_clk_in = '0;
    tx_positive_data_in = '0;
    tx_negative_data_in = '0;
  end

  // one recovered bit; the clock stands still between bits
  task automatic rx_bit(input int ch, input logic p, input logic m);
    // let the previous bit's inverse levels stand for a moment before the next bit
    #1;
    line_rx_plus[ch] = p;
    line_rx_minus[ch] = m;
    #62.5 rx_clk_in[ch] = 1'b1;
    #62.5 rx_clk_in[ch] = 1'b0;
    // hold is over: inverse levels expose a late sample
    line_rx_plus[ch] = ~p;
    line_rx_minus[ch] = ~m;
  endtask

  // one transmit bit, positive data doubles as the single-rail input
  task automatic tx_bit(input int ch, input logic p, input logic m);
    #1;
    tx_positive_data_in[ch] = p;
    tx_negative_data_in[ch] = m;
    #62.5 tx_clk_in[ch] = 1'b1;
    #62.5 tx_clk_in[ch] = 1'b0;
    tx_positive_data_in[ch] = ~p;
    tx_negative_data_in[ch] = ~m;
  endtask
endmodule

//--- test_channel_rate_rail_ja_config.sv
// self-checking bench for the channel rate, rail and attenuator config block
`timescale 1ns/10ps
`include "crr_map.svh"
module test_channel_rate_rail_ja_config;
  import crr_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [2:0]  rx_clk_in;
  wire  [2:0]  line_rx_plus;
  wire  [2:0]  line_rx_minus;
  wire  [2:0]  tx_clk_in;
  wire  [2:0]  tx_positive_data_in;
  wire  [2:0]  tx_negative_data_in;
  wire  [2:0]  rx_positive_out;
  wire  [2:0]  rx_negative_or_violation_out;
  wire  [2:0]  tx_line_pos_out;
  wire  [2:0]  tx_line_neg_out;
  wire  [2:0]  codec_enable;
  wire  [5:0]  chan_rate;
  wire  [5:0]  atten_cfg;
  wire  [2:0]  atten_tx_path_select;
  wire  [2:0]  atten_fifo_reset;
  wire  [2:0]  aps_recovery_enable;
  wire         irq;
  int          num_errors;
  int          n_tests;
  logic [31:0] d;
  logic [2:0]  v;
  int          n;
  localparam logic [7:0] STAT = {`CRR_IRQ_STAT_IDX, 2'b00};
  localparam logic [7:0] MASK = {`CRR_IRQ_MASK_IDX, 2'b00};

  crr_channel_config #(.NCH(3)) crr_channel_config_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_clk_in(rx_clk_in), .line_rx_plus(line_rx_plus), .line_rx_minus(line_rx_minus),
    .tx_clk_in(tx_clk_in), .tx_positive_data_in(tx_positive_data_in),
    .tx_negative_data_in(tx_negative_data_in), .rx_positive_out(rx_positive_out),
    .rx_negative_or_violation_out(rx_negative_or_violation_out), .tx_line_pos_out(tx_line_pos_out),
    .tx_line_neg_out(tx_line_neg_out), .codec_enable(codec_enable), .chan_rate(chan_rate),
    .atten_cfg(atten_cfg), .atten_tx_path_select(atten_tx_path_select),
    .atten_fifo_reset(atten_fifo_reset), .aps_recovery_enable(aps_recovery_enable), .irq(irq));

  crr_link_partner #(.NCH(3)) crr_link_partner_i (
    .rx_clk_in(rx_clk_in), .line_rx_plus(line_rx_plus), .line_rx_minus(line_rx_minus),
    .tx_clk_in(tx_clk_in), .tx_positive_data_in(tx_positive_data_in),
    .tx_negative_data_in(tx_negative_data_in));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  function automatic logic [7:0] ctrl(input int ch);
    return {`CRR_CTRL_IDX0 + 6'(8 * ch), 2'b00};
  endfunction

  function automatic logic [7:0] ja(input int ch);
    return {`CRR_JA_IDX0 + 6'(8 * ch), 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(a, 1'b1, wd, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rdv);
    bus(a, 1'b0, 32'h0000_0000, rdv);
  endtask

  // counts pulse cycles over a short window after a write
  task automatic pulses(input int ch, output int cnt);
    cnt = 0;
    repeat (3) begin
      cnt += int'(atten_fifo_reset[ch]);
      @(posedge hclk);
      #1;
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #300000;
    num_errors++;
    results();
  end

  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int ch = 0; ch < 3; ch++) begin
      rd(ctrl(ch), d);
      chk("ctrl reset", 32'h0, d);
      rd(ja(ch), d);
      chk("atten reset", 32'h0, d);
    end
    chk("codec reset", 32'h0, 32'(codec_enable));
    chk("rate reset", 32'h0, 32'(chan_rate));
    chk("recovery reset", 32'h7, 32'(aps_recovery_enable));
    for (int ch = 0; ch < 3; ch++) begin
      for (int i = 0; i < 8; i++) begin
        v = 3'(i);
        wr(ctrl(ch), 32'(v));
        chk("rate", 32'(v[2] ? CRR_RATE_E3 : (v[1] ? CRR_RATE_STS1 : CRR_RATE_DS3)), 32'(chan_rate[2*ch+:2]));
        chk("codec", 32'(v[0]), 32'(codec_enable[ch]));
        rd(ctrl(ch), d);
        chk("ctrl read", 32'(v), d);
      end
      wr(ctrl(ch), 32'h0);
      wr(ja(ch), 32'h0000_00FF);
      chk("atten cfg", 32'h3, 32'(atten_cfg[2*ch+:2]));
      chk("tx path", 32'h1, 32'(atten_tx_path_select[ch]));
      chk("recovery off", 32'h0, 32'(aps_recovery_enable[ch]));
      pulses(ch, n);
      chk("fifo reset pulse", 32'h1, 32'(n));
      rd(ja(ch), d);
      chk("atten read", 32'h1F, d);
      wr(ja(ch), 32'h0000_000D);
      pulses(ch, n);
      chk("fifo reset held", 32'h0, 32'(n));
      chk("rx path", 32'h0, 32'(atten_tx_path_select[ch]));
      chk("recovery on", 32'h1, 32'(aps_recovery_enable[ch]));
      wr(ja(ch), 32'h0000_0002);
      chk("atten cfg off", 32'h0, 32'(atten_cfg[2*ch+:2]));
      wr(ja(ch), 32'h0);
    end
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, d);
    chk("unmapped", 32'h0, d);
    chk("response", 32'h0, 32'(hresp));
    // single-rail on channel 0, violation masked then unmasked
    wr(ctrl(0), 32'h1);
    chk("codec on", 32'h1, 32'(codec_enable[0]));
    crr_link_partner_i.rx_bit(0, 1'b0, 1'b1);
    chk("rx mark", 32'h1, 32'(rx_positive_out[0]));
    crr_link_partner_i.rx_bit(0, 1'b1, 1'b0);
    chk("no violation", 32'h0, 32'(rx_negative_or_violation_out[0]));
    crr_link_partner_i.rx_bit(0, 1'b1, 1'b0);
    chk("violation", 32'h1, 32'(rx_negative_or_violation_out[0]));
    chk("irq masked", 32'h0, 32'(irq));
    rd(STAT, d);
    chk("status", 32'h1, d);
    wr(MASK, 32'h1);
    crr_link_partner_i.rx_bit(0, 1'b1, 1'b0);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h1, 32'(irq));
    rd(STAT, d);
    chk("status again", 32'h1, d);
    chk("irq cleared", 32'h0, 32'(irq));
    // excessive zeros: the third zero flags at the slower rates, the fourth at E3
    repeat (2) crr_link_partner_i.rx_bit(0, 1'b0, 1'b0);
    chk("zeros short", 32'h0, 32'(rx_negative_or_violation_out[0]));
    crr_link_partner_i.rx_bit(0, 1'b0, 1'b0);
    chk("zeros slow", 32'h1, 32'(rx_negative_or_violation_out[0]));
    wr(ctrl(0), 32'h5);
    crr_link_partner_i.rx_bit(0, 1'b0, 1'b1);
    repeat (3) crr_link_partner_i.rx_bit(0, 1'b0, 1'b0);
    chk("zeros e3 short", 32'h0, 32'(rx_negative_or_violation_out[0]));
    crr_link_partner_i.rx_bit(0, 1'b0, 1'b0);
    chk("zeros e3", 32'h1, 32'(rx_negative_or_violation_out[0]));
    crr_link_partner_i.tx_bit(0, 1'b1, 1'b0);
    chk("tx mark pos", 32'h1, 32'({tx_line_pos_out[0], tx_line_neg_out[0]} == 2'b10));
    crr_link_partner_i.tx_bit(0, 1'b1, 1'b0);
    chk("tx mark neg", 32'h1, 32'({tx_line_pos_out[0], tx_line_neg_out[0]} == 2'b01));
    wr(ctrl(0), 32'h0);
    for (int ch = 0; ch < 3; ch++) begin
      chk("codec off", 32'h0, 32'(codec_enable[ch]));
      crr_link_partner_i.rx_bit(ch, 1'b1, 1'b0);
      chk("rx pos", 32'h2, 32'({rx_positive_out[ch], rx_negative_or_violation_out[ch]}));
      crr_link_partner_i.rx_bit(ch, 1'b0, 1'b1);
      chk("rx neg", 32'h1, 32'({rx_positive_out[ch], rx_negative_or_violation_out[ch]}));
      crr_link_partner_i.rx_bit(ch, 1'b0, 1'b0);
      chk("rx idle", 32'h0, 32'({rx_positive_out[ch], rx_negative_or_violation_out[ch]}));
      crr_link_partner_i.tx_bit(ch, 1'b1, 1'b0);
      chk("tx pos", 32'h2, 32'({tx_line_pos_out[ch], tx_line_neg_out[ch]}));
      crr_link_partner_i.tx_bit(ch, 1'b0, 1'b1);
      chk("tx neg", 32'h1, 32'({tx_line_pos_out[ch], tx_line_neg_out[ch]}));
    end
    results();
  end
endmodule
